/* File: ssw_pkg.sv */
// package for the supply supervisor and watchdog
package ssw_pkg;
   // clock rate and timing figures
   localparam int unsigned CLK_HZ          = 25000000;
   localparam int unsigned RST_STRETCH_MS  = 200;
   localparam int unsigned WDT_TIMEOUT_MS  = 1600;
   localparam int unsigned DEBOUNCE_US     = 1000;
   localparam int unsigned RST_STRETCH_CYC = (CLK_HZ / 1000) * RST_STRETCH_MS;
   localparam int unsigned WDT_TIMEOUT_CYC = (CLK_HZ / 1000) * WDT_TIMEOUT_MS;
   localparam int unsigned DEBOUNCE_CYC    = (CLK_HZ / 1000000) * DEBOUNCE_US;
   localparam int          CNT_W           = 32;
   // reset values of outputs and synchroniser stages
   localparam logic        RST_N_INIT      = 1'b0;
   localparam logic        ALARM_N_INIT    = 1'b1;
   localparam logic        PFAIL_N_INIT    = 1'b1;
   localparam logic [1:0]  SYNC_INIT       = 2'b11;

   // raw inputs from pins
   typedef struct packed {
      logic supply_low;
      logic manual_reset_n;
      logic power_fail_sense;
      logic watchdog_kick;
      logic kick_float;
   } ssw_pins_t;

   // supervisory outputs
   typedef struct packed {
      logic reset_n;
      logic reset;
      logic watchdog_alarm_n;
      logic power_fail_flag_n;
   } ssw_outs_t;

   // reset stretcher states
   typedef enum logic [1:0] {
      SSW_HOLD    = 2'b00,
      SSW_STRETCH = 2'b01,
      SSW_RUN     = 2'b10
   } ssw_state_t;
endpackage

/* File: ssw_sync.sv */
// two-flop synchroniser bank for pin inputs
`timescale 1ns/1ps
module ssw_sync #(
   parameter int W = 5
) (
   input  wire logic         mclk,    // system clock
   input  wire logic         sys_rst, // async reset, active high
   input  wire logic         ce,      // clock enable
   input  wire logic [W-1:0] d,       // asynchronous inputs
   output logic      [W-1:0] q        // synchronised outputs
);
   import ssw_pkg::*;
   // one two-stage chain per bit
   for (genvar i = 0; i < W; i++) begin : g_bit
      logic [1:0] st_r;
      always_ff @(posedge mclk or posedge sys_rst) begin
         if (sys_rst) begin
            st_r <= SYNC_INIT;
         end else if (ce) begin
            st_r <= {st_r[0], d[i]};
         end
      end
      assign q[i] = st_r[1];
   end
endmodule

/* File: ssw_top.sv */
// supply supervisor with reset stretcher and watchdog
// Operation
// - low manual reset input starts reset
// - manual reset input debounced internally
// - power-fail flag follows comparator result, not inverted
// - alarm low after kick idle past timeout
// - every kick edge restarts watchdog count
// - watchdog count cleared while reset asserted
// - floating kick input disables watchdog timing
// - reset pulse nominally 200 ms long
// - reset held while supply stays low
// - reset held 200 ms after cause ends
// - watchdog timeout never asserts reset itself
// - alarm holds until a kick edge or reset clears it
// - supply low forces alarm low three clocks later, without waiting for a timeout
// - active-high reset is complement of reset
// - timeout measured only after reset release
`timescale 1ns/1ps
module ssw_top
   import ssw_pkg::*;
#(
   parameter int unsigned STRETCH_CYC  = RST_STRETCH_CYC, // reset stretch length
   parameter int unsigned TIMEOUT_CYC  = WDT_TIMEOUT_CYC, // watchdog timeout
   parameter int unsigned DEBOUNCE_LEN = DEBOUNCE_CYC     // manual reset filter
) (
   input  wire logic               mclk,    // system clock, 25 MHz
   input  wire logic               sys_rst, // async reset, active high
   input  wire logic               ce,      // clock enable, freezes state when low
   input  wire ssw_pkg::ssw_pins_t pins,    // raw asynchronous pin levels
   output ssw_pkg::ssw_outs_t      outs     // supervisory outputs
);
   import ssw_pkg::*;

   ssw_pins_t           s;             // synchronised inputs
   ssw_state_t          st_r;          // stretcher state
   logic [CNT_W-1:0]    str_cnt_r;     // stretch counter
   logic [CNT_W-1:0]    wdt_cnt_r;     // watchdog counter
   logic [CNT_W-1:0]    deb_cnt_r;     // debounce counter
   logic                man_deb_r;     // debounced manual reset level
   logic                kick_prev_r;   // previous kick level
   logic                timeout_r;     // sticky timeout
   logic                reset_n_r;     // active-low reset output register
   logic                alarm_n_r;     // alarm output register
   logic                pfail_n_r;     // power-fail flag register
   logic                cause;         // any reset cause present
   logic                kick_edge;     // qualified kick edge

   // synchronise every pin input
   ssw_sync #(.W($bits(ssw_pins_t))) u_sync (
      .mclk    (mclk),
      .sys_rst (sys_rst),
      .ce      (ce),
      .d       (pins),
      .q       (s)
   );

   // manual reset debounce, level must be stable for the filter time
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         man_deb_r <= 1'b1;
         deb_cnt_r <= '0;
      end else if (ce) begin
         if (s.manual_reset_n == man_deb_r) begin
            deb_cnt_r <= '0;
         end else if (deb_cnt_r >= CNT_W'(DEBOUNCE_LEN - 1)) begin
            man_deb_r <= s.manual_reset_n;
            deb_cnt_r <= '0;
         end else begin
            deb_cnt_r <= deb_cnt_r + 1'b1;
         end
      end
   end

   // reset causes: supply low or manual reset low
   assign cause = s.supply_low | ~man_deb_r;

   // reset stretcher state machine
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         st_r      <= SSW_HOLD;
         str_cnt_r <= '0;
         reset_n_r <= RST_N_INIT;
      end else if (ce) begin
         case (st_r)
            SSW_HOLD: begin
               reset_n_r <= 1'b0;
               str_cnt_r <= '0;
               if (!cause) begin
                  st_r <= SSW_STRETCH;
               end
            end
            SSW_STRETCH: begin
               if (cause) begin
                  st_r      <= SSW_HOLD;
                  str_cnt_r <= '0;
               end else if (str_cnt_r >= CNT_W'(STRETCH_CYC - 1)) begin
                  st_r      <= SSW_RUN;
                  reset_n_r <= 1'b1;
               end else begin
                  str_cnt_r <= str_cnt_r + 1'b1;
               end
            end
            SSW_RUN: begin
               if (cause) begin
                  st_r      <= SSW_HOLD;
                  reset_n_r <= 1'b0;
               end
            end
            default: begin
               st_r      <= SSW_HOLD;
               reset_n_r <= 1'b0;
            end
         endcase
      end
   end

   // edges are ignored while the kick pin floats
   assign kick_edge = ~s.kick_float & (s.watchdog_kick ^ kick_prev_r);

   // watchdog counter and sticky timeout
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         kick_prev_r <= SYNC_INIT[1]; // same level as synced kick, no false edge
         wdt_cnt_r   <= '0;
         timeout_r   <= 1'b0;
      end else if (ce) begin
         kick_prev_r <= s.watchdog_kick;
         if (!reset_n_r || kick_edge) begin
            wdt_cnt_r <= '0;
            timeout_r <= 1'b0;
         end else if (s.kick_float) begin
            wdt_cnt_r <= '0;
         end else if (wdt_cnt_r >= CNT_W'(TIMEOUT_CYC - 1)) begin
            timeout_r <= 1'b1;
         end else begin
            wdt_cnt_r <= wdt_cnt_r + 1'b1;
         end
      end
   end

   // output registers
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         alarm_n_r <= ALARM_N_INIT;
         pfail_n_r <= PFAIL_N_INIT;
      end else if (ce) begin
         alarm_n_r <= ~(timeout_r | s.supply_low);
         pfail_n_r <= s.power_fail_sense;
      end
   end

   assign outs.reset_n           = reset_n_r;
   assign outs.reset             = ~reset_n_r;
   assign outs.watchdog_alarm_n  = alarm_n_r;
   assign outs.power_fail_flag_n = pfail_n_r;

   // reset output and manual reset debounce checks
   complement_a: assert property (@(posedge mclk) disable iff (sys_rst)
      outs.reset == ~outs.reset_n)
      else $error("reset outputs not complementary");
   supply_hold_a: assert property (@(posedge mclk) disable iff (sys_rst)
      ce && s.supply_low |=> !reset_n_r)
      else $error("reset released while supply low");
   manual_start_a: assert property (@(posedge mclk) disable iff (sys_rst)
      ce && !man_deb_r |=> !reset_n_r)
      else $error("manual reset did not start reset");
   debounce_hold_a: assert property (@(posedge mclk) disable iff (sys_rst)
      ce && s.manual_reset_n == man_deb_r |=> $stable(man_deb_r))
      else $error("debounced level moved without input change");
   stretch_hold_a: assert property (@(posedge mclk) disable iff (sys_rst)
      ce && st_r == SSW_STRETCH && str_cnt_r < CNT_W'(STRETCH_CYC - 1) |=> !reset_n_r)
      else $error("reset released during stretch");
   release_a: assert property (@(posedge mclk) disable iff (sys_rst)
      $rose(reset_n_r) |-> $past(str_cnt_r) == CNT_W'(STRETCH_CYC - 1))
      else $error("release before stretch");
   no_wdt_reset_a: assert property (@(posedge mclk) disable iff (sys_rst)
      ce && st_r == SSW_RUN && !cause |=> reset_n_r)
      else $error("reset without cause");

   // alarm and flag checks
   supply_alarm_a: assert property (@(posedge mclk) disable iff (sys_rst)
      ce && s.supply_low |=> !alarm_n_r)
      else $error("alarm not forced low");
   alarm_release_a: assert property (@(posedge mclk) disable iff (sys_rst)
      ce && !timeout_r && !s.supply_low |=> alarm_n_r)
      else $error("alarm low without cause");
   pfail_a: assert property (@(posedge mclk) disable iff (sys_rst)
      ce |=> pfail_n_r == $past(s.power_fail_sense))
      else $error("power-fail flag wrong");

   // watchdog counter checks
   wdt_clear_a: assert property (@(posedge mclk) disable iff (sys_rst)
      ce && !reset_n_r |=> wdt_cnt_r == 0 && !timeout_r)
      else $error("count not cleared");
   float_a: assert property (@(posedge mclk) disable iff (sys_rst)
      ce && s.kick_float && !timeout_r |=> !timeout_r)
      else $error("timeout while floating");
   float_count_a: assert property (@(posedge mclk) disable iff (sys_rst)
      ce && s.kick_float |=> wdt_cnt_r == 0)
      else $error("count ran while floating");
   edge_clear_a: assert property (@(posedge mclk) disable iff (sys_rst)
      ce && kick_edge |=> wdt_cnt_r == 0)
      else $error("edge did not clear count");
   edge_alarm_a: assert property (@(posedge mclk) disable iff (sys_rst)
      ce && kick_edge |=> !timeout_r)
      else $error("edge did not clear timeout");
   alarm_hold_a: assert property (@(posedge mclk) disable iff (sys_rst)
      ce && timeout_r && reset_n_r && !kick_edge |=> timeout_r)
      else $error("alarm dropped");
   timeout_gap_a: assert property (@(posedge mclk) disable iff (sys_rst)
      ce && !timeout_r && wdt_cnt_r < CNT_W'(TIMEOUT_CYC - 1) |=> !timeout_r)
      else $error("timeout before full count");

   // main scenarios
   cov_release_c: cover property (@(posedge mclk) disable iff (sys_rst) $rose(reset_n_r));
   cov_timeout_c: cover property (@(posedge mclk) disable iff (sys_rst) $rose(timeout_r));
   cov_manual_c:  cover property (@(posedge mclk) disable iff (sys_rst) $fell(man_deb_r));
   cov_pfail_c:   cover property (@(posedge mclk) disable iff (sys_rst) $fell(pfail_n_r));
   cov_float_c:   cover property (@(posedge mclk) disable iff (sys_rst) $rose(s.kick_float));
endmodule

/* File: ssw_host.sv */
// host model that toggles the watchdog kick line
`timescale 1ns/1ps
module ssw_host #(
   parameter int PERIOD = 10
) (
   input  wire logic mclk, // system clock
   input  wire logic en,   // kicking active
   output logic      kick  // kick level
);
   int   cnt   = 0;
   logic tog_r = 1'b0;
   // toggle well inside the timeout while active
   always @(posedge mclk) begin
      if (en) begin
         cnt <= (cnt >= PERIOD - 1) ? 0 : cnt + 1;
         if (cnt >= PERIOD - 1) begin
            tog_r <= ~tog_r;
         end
      end
   end
   assign kick = tog_r;
endmodule

/* File: ssw_top_bench.sv */
// testbench for the supply supervisor and watchdog
`timescale 1ns/1ps
module ssw_top_bench;
   import ssw_pkg::*;
   localparam int STR = 20;
   localparam int TMO = 50;
   localparam int DBL = 4;
   logic      mclk = 1'b0;
   logic      sys_rst = 1'b1;
   logic      sup_low = 1'b0;
   logic      man_rst_n = 1'b1;
   logic      ce = 1'b1;
   logic      sense = 1'b1;
   logic      kfloat = 1'b0;
   logic      host_en = 1'b1;
   wire logic kick;
   ssw_pins_t pins;
   ssw_outs_t outs;
   int        num_errors = 0;
   int        compares = 0;
   int        n;
   assign pins = '{sup_low, man_rst_n, sense, kick, kfloat};
   initial forever #20 mclk = ~mclk;
   ssw_top #(.STRETCH_CYC(STR), .TIMEOUT_CYC(TMO), .DEBOUNCE_LEN(DBL)) i_dut (
      .mclk(mclk), .sys_rst(sys_rst), .ce(ce), .pins(pins), .outs(outs));
   ssw_host #(.PERIOD(10)) i_host (.mclk(mclk), .en(host_en), .kick(kick));
   // compare one value and count it
   task automatic check(input logic got, input logic exp);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: got %b, expected %b", $time, got, exp);
      end
   endtask
   task automatic close_out;
      $display("compares %0d num_errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic cyc(input int k);
      repeat (k) @(negedge mclk);
   endtask
   // bounded wait for reset release, n holds the cycles taken
   task automatic wait_rel;
      n = 0;
      while (outs.reset_n !== 1'b1 && n < 500) begin
         cyc(1);
         n++;
      end
      if (n >= 500) begin
         num_errors++;
         $display("wrong value at %0t: reset never released", $time);
         close_out();
      end
   endtask
   task automatic t_por;
      check(outs.reset_n, 1'b0);
      check(outs.reset, 1'b1);
      wait_rel();
      check(n >= STR && n <= STR + 6, 1'b1);
      check(outs.reset, 1'b0);
      $display("power-on test done");
   endtask
   task automatic t_pfail;
      @(posedge mclk) sense <= 1'b0;
      cyc(4);
      check(outs.power_fail_flag_n, 1'b0);
      @(posedge mclk) sense <= 1'b1;
      cyc(4);
      check(outs.power_fail_flag_n, 1'b1);
      $display("power-fail test done");
   endtask
   task automatic t_supply;
      @(posedge mclk) sup_low <= 1'b1;
      cyc(4);
      check(outs.reset_n, 1'b0);
      check(outs.watchdog_alarm_n, 1'b0);
      cyc(60);
      check(outs.reset_n, 1'b0);
      @(posedge mclk) sup_low <= 1'b0;
      cyc(4);
      check(outs.watchdog_alarm_n, 1'b1);
      check(outs.reset_n, 1'b0);
      wait_rel();
      check(n >= STR - 4 && n <= STR + 4, 1'b1);
      $display("supply test done");
   endtask
   task automatic t_manual;
      @(posedge mclk) man_rst_n <= 1'b0;
      cyc(2);
      @(posedge mclk) man_rst_n <= 1'b1;
      cyc(10);
      check(outs.reset_n, 1'b1);
      @(posedge mclk) man_rst_n <= 1'b0;
      host_en <= 1'b0;
      cyc(DBL + 8);
      check(outs.reset_n, 1'b0);
      check(outs.reset, 1'b1);
      cyc(TMO + 10);
      check(outs.watchdog_alarm_n, 1'b1);
      @(posedge mclk) man_rst_n <= 1'b1;
      host_en <= 1'b1;
      wait_rel();
      check(n >= STR && n <= STR + DBL + 8, 1'b1);
      $display("manual reset test done");
   endtask
   task automatic t_wdog;
      @(posedge mclk) host_en <= 1'b0;
      cyc(TMO - 12);
      check(outs.watchdog_alarm_n, 1'b1);
      cyc(20);
      check(outs.watchdog_alarm_n, 1'b0);
      check(outs.reset_n, 1'b1);
      cyc(30);
      check(outs.watchdog_alarm_n, 1'b0);
      @(posedge mclk) host_en <= 1'b1;
      cyc(15);
      check(outs.watchdog_alarm_n, 1'b1);
      cyc(TMO + 20);
      check(outs.watchdog_alarm_n, 1'b1);
      $display("watchdog test done");
   endtask
   task automatic t_float;
      @(posedge mclk) kfloat <= 1'b1;
      host_en <= 1'b0;
      cyc(TMO * 2);
      check(outs.watchdog_alarm_n, 1'b1);
      @(posedge mclk) kfloat <= 1'b0;
      cyc(TMO + 12);
      check(outs.watchdog_alarm_n, 1'b0);
      $display("floating kick test done");
   endtask
   // clock enable low freezes the alarm and power-fail flag outputs
   task automatic t_freeze;
      @(posedge mclk) ce <= 1'b0;
      host_en <= 1'b0;
      sense   <= 1'b0;
      cyc(TMO + 20);
      check(outs.watchdog_alarm_n, 1'b1);
      check(outs.power_fail_flag_n, 1'b1);
      @(posedge mclk) ce <= 1'b1;
      cyc(4);
      check(outs.power_fail_flag_n, 1'b0);
      @(posedge mclk) sense <= 1'b1;
      cyc(4);
      check(outs.power_fail_flag_n, 1'b1);
      $display("clock enable test done");
   endtask
   // main sequence
   initial begin
      repeat (8) @(posedge mclk);
      sys_rst <= 1'b0;
      cyc(1);
      t_por();
      t_pfail();
      t_supply();
      t_manual();
      t_wdog();
      t_freeze();
      t_float();
      close_out();
   end
endmodule
